/* File: core/pnp_cfg.svh */
// Constants for the partner next page receive register block
`ifndef PNP_CFG_SVH
`define PNP_CFG_SVH

`define PNP_ADDR_CTRL 8'h6E
`define PNP_ADDR_OFS 8'h6F
`define PNP_ADDR_DATA 8'hA0
`define PNP_TBL_MSB 7
`define PNP_TBL_LSB 5
`define PNP_PORT_MSB 3
`define PNP_PORT_LSB 0
`define PNP_TBL_EEE 3'h1
`define PNP_PORT_FIRST 4'h3
`define PNP_PORT_LAST 4'h4
`define PNP_OFS_HI 8'h10
`define PNP_OFS_LO 8'h11
`define PNP_BIT_MORE 15
`define PNP_BIT_ACK 14
`define PNP_BIT_MSG 13
`define PNP_BIT_COMPLY 12
`define PNP_BIT_TGL 11
`define PNP_ACK_MASK 16'h4000
`define PNP_CONSIST_CNT 2'h3
`define PNP_PAGE_RST 16'h0000
`define PNP_BYTE_RST 8'h00

`endif

/* File: core/pnp_pkg.sv */
// Types shared by the partner next page receive register block
package pnp_pkg;
	typedef logic [15:0] pnp_word_t;
	typedef enum logic [1:0] {PNP_SEL_NONE, PNP_SEL_P3, PNP_SEL_P4} pnp_sel_t;
endpackage

/* File: core/pnp_page_if.sv */
// Link codeword stream into one port's page catcher, and its captured state back
`timescale 1ns/10ps
interface pnp_page_if;
	logic word_valid;
	pnp_pkg::pnp_word_t word;
	logic is_base;
	pnp_pkg::pnp_word_t page;
	logic ack;
	logic tgl_err;
	modport feed (output word_valid, output word, output is_base,
		input page, input ack, input tgl_err);
	modport catcher (input word_valid, input word, input is_base,
		output page, output ack, output tgl_err);
endinterface

/* File: core/pnp_page_rx.sv */
// Per-port catcher of the partner's next page with consistency and toggle checks
`timescale 1ns/10ps
`include "pnp_cfg.svh"
module pnp_page_rx (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Codeword stream and captured page
	pnp_page_if.catcher rx
);
	logic [1:0] cnt_r, cnt_nxt;
	pnp_pkg::pnp_word_t last_r, last_nxt, page_r, page_nxt;
	logic prev_tgl_r, prev_tgl_nxt, ack_r, ack_nxt, err_r, err_nxt;
	logic match, accept;

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		cnt_nxt = cnt_r;
		last_nxt = last_r;
		page_nxt = page_r;
		prev_tgl_nxt = prev_tgl_r;
		ack_nxt = ack_r;
		err_nxt = err_r;
		match = 1'b0;
		accept = 1'b0;
		if (rx.word_valid) begin
			// Ack bit is ignored when comparing bursts
			match = (cnt_r != 2'h0) &&
				((rx.word & ~`PNP_ACK_MASK) == (last_r & ~`PNP_ACK_MASK));
			last_nxt = rx.word;
			if (!match) begin
				cnt_nxt = 2'h1;
				ack_nxt = 1'b0;
			end else if (cnt_r != `PNP_CONSIST_CNT) begin
				cnt_nxt = cnt_r + 2'h1;
			end
			accept = match && (cnt_r == `PNP_CONSIST_CNT - 2'h1);
			if (accept) begin
				ack_nxt = 1'b1;
				if (rx.is_base) begin
					prev_tgl_nxt = rx.word[`PNP_BIT_TGL];
				end else if (rx.word[`PNP_BIT_TGL] != prev_tgl_r) begin
					// All fields move together on an accepted page
					page_nxt = rx.word;
					prev_tgl_nxt = rx.word[`PNP_BIT_TGL];
				end else begin
					// Stale toggle means a repeated page: keep old contents
					err_nxt = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r <= 2'h0;
			last_r <= `PNP_PAGE_RST;
			page_r <= `PNP_PAGE_RST;
			prev_tgl_r <= 1'b0;
			ack_r <= 1'b0;
			err_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			last_r <= last_nxt;
			page_r <= page_nxt;
			prev_tgl_r <= prev_tgl_nxt;
			ack_r <= ack_nxt;
			err_r <= err_nxt;
		end
	end

	assign rx.page = page_r;
	assign rx.ack = ack_r;
	assign rx.tgl_err = err_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_base_accept;
		accept && rx.is_base;
	endsequence
	sequence s_next_accept;
		accept && !rx.is_base && (rx.word[`PNP_BIT_TGL] != prev_tgl_r);
	endsequence

	a_ack_after_three: assert property ($rose(ack_r) |-> cnt_r == 2'h3)
		else $error("ack rose without three consistent bursts");
	a_base_sets_tgl: assert property (s_base_accept |=> prev_tgl_r == $past(rx.word[11]))
		else $error("base page toggle not recorded");
	a_tgl_alternates: assert property ($changed(page_r) |-> page_r[11] != $past(prev_tgl_r))
		else $error("captured page toggle did not alternate");
	a_page_taken: assert property (s_next_accept |=> page_r == $past(rx.word))
		else $error("accepted next page not captured whole");
	a_page_only_new: assert property (!accept || rx.is_base
		|| rx.word[`PNP_BIT_TGL] == prev_tgl_r |=> $stable(page_r))
		else $error("page changed without an accepted next page");
	a_err_sticky: assert property (err_r |=> err_r)
		else $error("toggle error cleared without reset");
endmodule // pnp_page_rx

/* File: core/pnp_regs.sv */
// Indirect access to the partner next page receive register of ports 3 and 4
//
// Overview of operation
// - Offset byte chooses byte returned at data
// - Offset 0x10 upper byte, 0x11 lower
// - Bit 15 shows partner more-pages flag
// - Bit 14 shows partner acknowledge
// - Acknowledge after three consistent bursts
// - Bit 13 message versus unformatted page
// - Bit 12 shows partner will-comply flag
// - Toggle alternates from previous codeword
// - First toggle inverts base page bit
// - Bits 10:0 hold received code field
`timescale 1ns/10ps
`include "pnp_cfg.svh"
module pnp_regs #(
	parameter int NPORTS = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Byte register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	// Received link codewords, index 0 is port 3
	input wire logic [NPORTS-1:0] lp_word_valid,
	input wire logic [NPORTS-1:0][15:0] lp_word,
	input wire logic [NPORTS-1:0] lp_is_base,
	// Negotiation status back to the link side
	output logic [NPORTS-1:0] ack_tx,
	output logic [NPORTS-1:0] tgl_err
);
	logic [7:0] ctrl_r, ctrl_nxt, ofs_r, ofs_nxt, rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;
	pnp_pkg::pnp_word_t page_w [NPORTS];
	pnp_pkg::pnp_word_t sel_page;
	pnp_pkg::pnp_sel_t sel;
	logic [7:0] data_byte;

	////////////////////////////////////////////////////////////////////////////
	genvar gi;
	generate
		for (gi = 0; gi < NPORTS; gi++) begin : g_port
			pnp_page_if pif ();
			assign pif.word_valid = lp_word_valid[gi];
			assign pif.word = lp_word[gi];
			assign pif.is_base = lp_is_base[gi];
			assign page_w[gi] = pif.page;
			// Both come straight from catcher flops
			assign ack_tx[gi] = pif.ack;
			assign tgl_err[gi] = pif.tgl_err;
			pnp_page_rx u_rx (
				.clk(clk),
				.rst_b(rst_b),
				.rx(pif.catcher)
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		sel = pnp_pkg::PNP_SEL_NONE;
		sel_page = `PNP_PAGE_RST;
		data_byte = `PNP_BYTE_RST;
		if (ctrl_r[`PNP_TBL_MSB:`PNP_TBL_LSB] == `PNP_TBL_EEE) begin
			if (ctrl_r[`PNP_PORT_MSB:`PNP_PORT_LSB] == `PNP_PORT_FIRST) begin
				sel = pnp_pkg::PNP_SEL_P3;
			end else if (ctrl_r[`PNP_PORT_MSB:`PNP_PORT_LSB] == `PNP_PORT_LAST) begin
				sel = pnp_pkg::PNP_SEL_P4;
			end
		end
		case (sel)
			pnp_pkg::PNP_SEL_P3: sel_page = page_w[0];
			pnp_pkg::PNP_SEL_P4: sel_page = page_w[NPORTS-1];
			default: sel_page = `PNP_PAGE_RST;
		endcase
		// Other offsets of the table live elsewhere and read zero here
		if (sel != pnp_pkg::PNP_SEL_NONE && ofs_r == `PNP_OFS_HI) begin
			data_byte = sel_page[15:8];
		end else if (sel != pnp_pkg::PNP_SEL_NONE && ofs_r == `PNP_OFS_LO) begin
			data_byte = sel_page[7:0];
		end
	end

	always_comb begin
		ctrl_nxt = ctrl_r;
		ofs_nxt = ofs_r;
		rdata_nxt = rdata_r;
		rvalid_nxt = reg_rd;
		if (reg_wr && reg_addr == `PNP_ADDR_CTRL) begin
			ctrl_nxt = reg_wdata;
		end else if (reg_wr && reg_addr == `PNP_ADDR_OFS) begin
			ofs_nxt = reg_wdata;
		end
		// Writes to the data byte are dropped: the page is read-only
		if (reg_rd) begin
			if (reg_addr == `PNP_ADDR_CTRL) begin
				rdata_nxt = ctrl_r;
			end else if (reg_addr == `PNP_ADDR_OFS) begin
				rdata_nxt = ofs_r;
			end else if (reg_addr == `PNP_ADDR_DATA) begin
				rdata_nxt = data_byte;
			end else begin
				rdata_nxt = `PNP_BYTE_RST;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_r <= `PNP_BYTE_RST;
			ofs_r <= `PNP_BYTE_RST;
			rdata_r <= `PNP_BYTE_RST;
			rvalid_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			ofs_r <= ofs_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	// Field view of the selected page, named as software sees the bits
	logic more_pages_flag, peer_ack_flag, message_kind_flag, will_comply_flag;
	logic [2:0] code_top;
	assign more_pages_flag = sel_page[`PNP_BIT_MORE];
	assign peer_ack_flag = sel_page[`PNP_BIT_ACK];
	assign message_kind_flag = sel_page[`PNP_BIT_MSG];
	assign will_comply_flag = sel_page[`PNP_BIT_COMPLY];
	assign code_top = sel_page[10:8];

	sequence s_rd_p3(logic [7:0] o);
		reg_rd && reg_addr == 8'hA0 && ctrl_r == 8'h23 && ofs_r == o;
	endsequence
	sequence s_rd_p4(logic [7:0] o);
		reg_rd && reg_addr == 8'hA0 && ctrl_r == 8'h24 && ofs_r == o;
	endsequence
	// Any mapped table and port, either byte
	sequence s_rd_sel_hi;
		reg_rd && reg_addr == 8'hA0 && sel != pnp_pkg::PNP_SEL_NONE && ofs_r == 8'h10;
	endsequence
	sequence s_rd_sel_lo;
		reg_rd && reg_addr == 8'hA0 && sel != pnp_pkg::PNP_SEL_NONE && ofs_r == 8'h11;
	endsequence

	// Read answer timing: no wait states, data held between reads
	a_rd_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read answer not one cycle after request");
	a_no_answer: assert property (!reg_rd |=> !reg_rvalid)
		else $error("read answer without a request");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_rd: assert property (reg_rd && reg_addr != 8'h6E && reg_addr != 8'h6F
		&& reg_addr != 8'hA0 |=> reg_rdata == 8'h00)
		else $error("unmapped address did not read zero");

	// Control and offset bytes; the data byte takes no writes
	a_ctrl_write: assert property (reg_wr && reg_addr == 8'h6E
		|=> ctrl_r == $past(reg_wdata))
		else $error("control byte write lost");
	a_ofs_write: assert property (reg_wr && reg_addr == 8'h6F
		|=> ofs_r == $past(reg_wdata))
		else $error("offset byte write lost");
	a_data_ro: assert property (reg_wr && reg_addr == 8'hA0
		|=> $stable(ctrl_r) && $stable(ofs_r))
		else $error("write to the data byte changed state");

	// Byte selection by table, port and offset
	a_rd_upper: assert property (s_rd_p3(8'h10)
		|=> reg_rdata == $past(page_w[0][15:8]))
		else $error("upper byte of port 3 page not returned");
	a_rd_lower: assert property (s_rd_p3(8'h11)
		|=> reg_rdata == $past(page_w[0][7:0]))
		else $error("lower byte of port 3 page not returned");
	a_rd_p4_upper: assert property (s_rd_p4(8'h10)
		|=> reg_rdata == $past(page_w[NPORTS-1][15:8]))
		else $error("upper byte of port 4 page not returned");
	a_rd_p4_lower: assert property (s_rd_p4(8'h11)
		|=> reg_rdata == $past(page_w[NPORTS-1][7:0]))
		else $error("lower byte of port 4 page not returned");
	a_wrong_table: assert property (reg_rd && reg_addr == 8'hA0 && ctrl_r[7:5] != 3'h1
		|=> reg_rdata == 8'h00)
		else $error("data byte returned for another table");
	a_wrong_port: assert property (reg_rd && reg_addr == 8'hA0 && ctrl_r[3:0] != 4'h3
		&& ctrl_r[3:0] != 4'h4 |=> reg_rdata == 8'h00)
		else $error("data byte returned for a port without the register");
	a_wrong_offset: assert property (reg_rd && reg_addr == 8'hA0 && ofs_r != 8'h10
		&& ofs_r != 8'h11 |=> reg_rdata == 8'h00)
		else $error("data byte returned for another offset");

	// Field positions; a page may still change between the two byte reads
	a_more_pages: assert property (s_rd_sel_hi
		|=> reg_rdata[7] == $past(more_pages_flag))
		else $error("more-pages flag not in bit 15");
	a_peer_ack: assert property (s_rd_sel_hi
		|=> reg_rdata[6] == $past(peer_ack_flag))
		else $error("acknowledge flag not in bit 14");
	a_msg_kind: assert property (s_rd_sel_hi
		|=> reg_rdata[5] == $past(message_kind_flag))
		else $error("message kind flag not in bit 13");
	a_will_comply: assert property (s_rd_sel_hi
		|=> reg_rdata[4] == $past(will_comply_flag))
		else $error("will-comply flag not in bit 12");
	a_code_field: assert property (s_rd_sel_hi
		|=> reg_rdata[2:0] == $past(code_top))
		else $error("upper code field bits misplaced");
	a_code_low: assert property (s_rd_sel_lo
		|=> reg_rdata == $past(sel_page[7:0]))
		else $error("lower code field bits misplaced");
endmodule // pnp_regs

/* File: test/pnp_lp_model.sv */
// Link partner model: sends codewords as runs of bursts
`timescale 1ns/10ps
`include "pnp_cfg.svh"
module pnp_lp_model (
	// Clock
	clk,
	// Codeword stream
	word_valid,
	word,
	is_base
);
	input wire logic clk;
	output logic word_valid;
	output logic [15:0] word;
	output logic is_base;
	initial begin
		word_valid = 1'b0;
		word = 16'h0000;
		is_base = 1'b0;
	end
	// Odd bursts flip the ack bit so the device must ignore it when comparing
	task automatic send(input logic [15:0] w, input logic base, input int n);
		for (int i = 0; i < n; i++) begin
			word_valid <= 1'b1;
			word <= w ^ (i[0] ? `PNP_ACK_MASK : 16'h0000);
			is_base <= base;
			@(posedge clk);
		end
		word_valid <= 1'b0;
		// Idle word is the inverse so a stale copy cannot pass
		word <= ~w;
		@(posedge clk);
	endtask
endmodule // pnp_lp_model

/* File: test/testbench.sv */
// Self-checking bench for the partner next page receive register
`timescale 1ns/10ps
`include "pnp_cfg.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module testbench;
	logic clk, rst_b, reg_wr, reg_rd, reg_rvalid;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, b;
	wire [1:0] lv, lb;
	logic [1:0] ack_tx, tgl_err;
	wire [1:0][15:0] lw;
	int n_mismatch = 0;
	int tests_run = 0;
	pnp_pkg::pnp_word_t pg;
	logic [7:0] bad_ctrl [3] = '{8'h43, 8'h25, 8'h23};
	logic [7:0] bad_ofs [3] = '{8'h10, 8'h10, 8'h12};
	pnp_lp_model lp3 (.clk(clk), .word_valid(lv[0]), .word(lw[0]), .is_base(lb[0]));
	pnp_lp_model lp4 (.clk(clk), .word_valid(lv[1]), .word(lw[1]), .is_base(lb[1]));
	pnp_regs #(.NPORTS(2)) DUT (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .lp_word_valid(lv), .lp_word(lw), .lp_is_base(lb),
		.ack_tx(ack_tx), .tgl_err(tgl_err));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic results;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1)
		d = reg_rdata;
		@(posedge clk);
	endtask
	task automatic rdpage(input logic [3:0] p, output pnp_pkg::pnp_word_t w);
		wr(`PNP_ADDR_CTRL, {`PNP_TBL_EEE, 1'b0, p});
		wr(`PNP_ADDR_OFS, `PNP_OFS_HI);
		rd(`PNP_ADDR_DATA, w[15:8]);
		wr(`PNP_ADDR_OFS, `PNP_OFS_LO);
		rd(`PNP_ADDR_DATA, w[7:0]);
	endtask
	task automatic st(input logic [1:0] a, input logic [1:0] e);
		#1;
		`CHK(ack_tx, a)
		`CHK(tgl_err, e)
		`CHK(reg_rvalid, 1'b0)
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		n_mismatch++;
		results();
	end
	initial begin
		rst_b = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdpage(4'h3, pg);
		`CHK(pg, `PNP_PAGE_RST)
		wr(`PNP_ADDR_DATA, 8'hFF);
		rdpage(4'h4, pg);
		`CHK(pg, `PNP_PAGE_RST)
		$display("test reset done");
		lp3.send(16'h0800, 1'b1, 3);
		st(2'b01, 2'b00);
		lp3.send(16'hF2A5, 1'b0, 3);
		rdpage(4'h3, pg);
		`CHK(pg, 16'hF2A5)
		lp3.send(16'h0C01, 1'b0, 3);
		rdpage(4'h3, pg);
		`CHK(pg, 16'h0C01)
		// Same toggle as the last exchanged page
		lp3.send(16'h2C00, 1'b0, 3);
		st(2'b01, 2'b01);
		// Two bursts only: never accepted
		lp3.send(16'h1000, 1'b0, 2);
		st(2'b00, 2'b01);
		rdpage(4'h3, pg);
		`CHK(pg, 16'h0C01)
		$display("test port three done");
		lp4.send(16'h0000, 1'b1, 3);
		lp4.send(16'h8800, 1'b0, 3);
		st(2'b10, 2'b01);
		rdpage(4'h4, pg);
		`CHK(pg, 16'h8800)
		wr(`PNP_ADDR_DATA, 8'h00);
		rdpage(4'h4, pg);
		`CHK(pg, 16'h8800)
		$display("test port four done");
		// Reset in mid-run clears pages, acknowledge and the sticky toggle error
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		st(2'b00, 2'b00);
		rdpage(4'h3, pg);
		`CHK(pg, `PNP_PAGE_RST)
		rdpage(4'h4, pg);
		`CHK(pg, `PNP_PAGE_RST)
		$display("test second reset done");
		for (int i = 0; i < 3; i++) begin
			wr(`PNP_ADDR_CTRL, bad_ctrl[i]);
			wr(`PNP_ADDR_OFS, bad_ofs[i]);
			rd(`PNP_ADDR_DATA, b);
			`CHK(b, `PNP_BYTE_RST)
		end
		rd(`PNP_ADDR_CTRL, b);
		`CHK(b, 8'h23)
		rd(8'h55, b);
		`CHK(b, `PNP_BYTE_RST)
		$display("test access done");
		results();
	end
endmodule // testbench
